// ### uef_pkg.sv
// Package with register map, field layout and carrier types of the endpoint FIFO access block.
package uef_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_FRAME_NUMBER_LOW   = 8'hBA;
  localparam logic [7:0] IDX_EP_IRQ_ENABLE      = 8'hC2;
  localparam logic [7:0] IDX_EP_FIFO_DATA_PORT  = 8'hCF;
  localparam logic [7:0] IDX_EP_RX_BYTE_COUNT   = 8'hE2;
  localparam logic [7:0] IDX_EP_INT_FLAGS       = 8'hF8;
  localparam logic [7:0] IDX_EVENT_STATUS       = 8'h40;
  localparam logic [7:0] IDX_EVENT_MASK         = 8'h41;

  // Block dimensions.
  localparam int EP_COUNT      = 3;
  localparam int EP_SEL_W      = 2;
  localparam int FIFO_PTR_W    = 6;
  localparam int BYTE_COUNT_W  = 7;
  localparam int FRAME_W       = 11;
  localparam int EVT_W         = 5;

  // Event status bit positions.
  localparam int EVT_EP0       = 0;
  localparam int EVT_SOF_OK    = 3;
  localparam int EVT_SOF_ERR   = 4;

  // Reset values and the byte count limit.
  localparam logic [EP_COUNT-1:0]     RST_FLAGS  = 3'h0;
  localparam logic [EP_COUNT-1:0]     RST_ENABLE = 3'h0;
  localparam logic [EVT_W-1:0]        RST_EVT    = 5'h00;
  localparam logic [FRAME_W-1:0]      RST_FRAME  = 11'h000;
  localparam logic [BYTE_COUNT_W-1:0] RST_COUNT  = 7'h00;
  localparam logic [BYTE_COUNT_W-1:0] COUNT_MAX  = 7'h7F;
  localparam logic [FIFO_PTR_W-1:0]   RST_PTR    = 6'h00;

  // Status sources of one endpoint.
  typedef struct packed {
    logic stall_or_crc_event;
    logic setup_received;
    logic out_bank1_received;
    logic out_bank0_received;
    logic transmit_complete;
  } uef_src_t;

  // Start-of-frame report from the packet engine.
  typedef struct packed {
    logic               valid;
    logic               crc_ok;
    logic [FRAME_W-1:0] frame;
  } uef_sof_t;

  // Complete register state of the block.
  typedef struct packed {
    logic [31:0]                                 dat;
    logic                                        ack;
    logic                                        irq;
    logic [EP_COUNT-1:0]                         flags;
    logic [EP_COUNT-1:0]                         flags_q;
    logic [EP_COUNT-1:0]                         en;
    logic [EVT_W-1:0]                            sticky;
    logic [EVT_W-1:0]                            mask;
    logic [FRAME_W-1:0]                          frame;
    logic [EP_COUNT-1:0][BYTE_COUNT_W-1:0]       count;
    logic [EP_COUNT-1:0][FIFO_PTR_W-1:0]         cpu_ptr;
    logic [EP_COUNT-1:0][FIFO_PTR_W-1:0]         eng_ptr;
    logic [7:0]                                  tx_data;
  } uef_state_t;

endpackage

// ### uef_endpoint_fifo.sv
// Endpoint flags, FIFO data port, byte counter and frame number with a Wishbone slave.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ns

module uef_endpoint_fifo
  import uef_pkg::*;
#(
  parameter int FIFO_DEPTH = 64
) (
  // Clock and reset.
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Wishbone slave.
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [9:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  // Interrupt.
  output logic                        irq_o,
  // Endpoint selection and FIFO reset.
  input  wire logic [EP_SEL_W-1:0]    endpoint_index_i,
  input  wire logic [EP_COUNT-1:0]    fifo_reset_i,
  // Packet engine side.
  input  wire uef_src_t [EP_COUNT-1:0] ep_src_i,
  input  wire logic                   pkt_start_i,
  input  wire logic [EP_SEL_W-1:0]    pkt_ep_i,
  input  wire logic                   rx_valid_i,
  input  wire logic [7:0]             rx_data_i,
  input  wire logic                   tx_rd_i,
  output logic      [7:0]             tx_data_o,
  input  wire uef_sof_t               sof_i
);

  uef_state_t s;
  uef_state_t next_s;

  logic [7:0] fifo_mem [0:EP_COUNT-1][0:FIFO_DEPTH-1];

  logic                  mem_we;
  logic [EP_SEL_W-1:0]   mem_ep;
  logic [FIFO_PTR_W-1:0] mem_ptr;
  logic [7:0]            mem_wdat;
  logic                  req;
  logic [7:0]            idx;
  logic                  sel_ok;
  logic                  dp_acc;
  logic                  cnt_rd;
  logic [7:0]            rd_byte;
  logic [FIFO_PTR_W-1:0] cur_ptr;
  logic [EVT_W-1:0]      evt_set;
  logic [EVT_W-1:0]      evt_clr;

  function automatic logic [FIFO_PTR_W-1:0] ptr_inc(input logic [FIFO_PTR_W-1:0] p);
    ptr_inc = p + {{(FIFO_PTR_W-1){1'b0}}, 1'b1};
  endfunction

  function automatic logic ep_valid(input logic [EP_SEL_W-1:0] e);
    ep_valid = (e < EP_SEL_W'(EP_COUNT));
  endfunction

  assign req     = wb_cyc_i & wb_stb_i & ~s.ack;
  assign idx     = wb_adr_i[9:2];
  assign sel_ok  = ep_valid(endpoint_index_i);
  assign cur_ptr = sel_ok ? s.cpu_ptr[endpoint_index_i] : RST_PTR;
  assign rd_byte = sel_ok ? fifo_mem[endpoint_index_i][cur_ptr] : 8'h00;
  assign dp_acc  = req & ~rx_valid_i & sel_ok & (idx == IDX_EP_FIFO_DATA_PORT);
  assign cnt_rd  = req & ~rx_valid_i & ~wb_we_i & (idx == IDX_EP_RX_BYTE_COUNT);

  always_comb begin
    next_s   = s;
    mem_we   = 1'b0;
    mem_ep   = pkt_ep_i;
    mem_ptr  = RST_PTR;
    mem_wdat = rx_data_i;
    evt_clr  = RST_EVT;
    next_s.ack = 1'b0;
    next_s.flags_q = s.flags;

    for (int e = 0; e < EP_COUNT; e++) begin
      next_s.flags[e] = |ep_src_i[e];
    end

    if (sof_i.valid && sof_i.crc_ok) begin
      next_s.frame = sof_i.frame;
    end

    // Packet engine: packet start, received bytes and transmitted bytes.
    if (ep_valid(pkt_ep_i)) begin
      if (pkt_start_i) begin
        next_s.eng_ptr[pkt_ep_i] = RST_PTR;
        next_s.count[pkt_ep_i] = RST_COUNT;
      end else if (rx_valid_i) begin
        mem_we  = 1'b1;
        mem_ptr = s.eng_ptr[pkt_ep_i];
        next_s.eng_ptr[pkt_ep_i] = ptr_inc(s.eng_ptr[pkt_ep_i]);
        if (s.count[pkt_ep_i] != COUNT_MAX) begin
          next_s.count[pkt_ep_i] = s.count[pkt_ep_i] + 7'h01;
        end
      end else if (tx_rd_i) begin
        next_s.tx_data = fifo_mem[pkt_ep_i][s.eng_ptr[pkt_ep_i]];
        next_s.eng_ptr[pkt_ep_i] = ptr_inc(s.eng_ptr[pkt_ep_i]);
      end
    end

    // Software access; waits while the engine writes the FIFO.
    if (req && !rx_valid_i) begin
      next_s.ack = 1'b1;
      next_s.dat = 32'h0000_0000;
      case (idx)
        IDX_EP_FIFO_DATA_PORT: begin
          if (sel_ok) begin
            if (wb_we_i) begin
              mem_we   = wb_sel_i[0];
              mem_ep   = endpoint_index_i;
              mem_ptr  = cur_ptr;
              mem_wdat = wb_dat_i[7:0];
            end else begin
              next_s.dat[7:0] = rd_byte;
            end
            next_s.cpu_ptr[endpoint_index_i] = ptr_inc(cur_ptr);
          end
        end
        IDX_EP_RX_BYTE_COUNT: begin
          if (sel_ok) begin
            next_s.dat[7:0] = {1'b0, s.count[endpoint_index_i]};
          end
        end
        IDX_FRAME_NUMBER_LOW: begin
          next_s.dat[7:0] = s.frame[7:0];
        end
        IDX_EP_INT_FLAGS: begin
          next_s.dat[EP_COUNT-1:0] = s.flags;
        end
        IDX_EP_IRQ_ENABLE: begin
          if (wb_we_i && wb_sel_i[0]) begin
            next_s.en = wb_dat_i[EP_COUNT-1:0];
          end
          next_s.dat[EP_COUNT-1:0] = s.en;
        end
        IDX_EVENT_STATUS: begin
          if (wb_we_i && wb_sel_i[0]) begin
            evt_clr = wb_dat_i[EVT_W-1:0];
          end
          next_s.dat[EVT_W-1:0] = s.sticky;
        end
        IDX_EVENT_MASK: begin
          if (wb_we_i && wb_sel_i[0]) begin
            next_s.mask = wb_dat_i[EVT_W-1:0];
          end
          next_s.dat[EVT_W-1:0] = s.mask;
        end
        default: begin
          next_s.dat = 32'h0000_0000;
        end
      endcase
    end

    // FIFO pointer reset from the endpoint control logic.
    for (int e = 0; e < EP_COUNT; e++) begin
      if (fifo_reset_i[e]) begin
        next_s.cpu_ptr[e] = RST_PTR;
        next_s.eng_ptr[e] = RST_PTR;
      end
    end

    // Sticky events; a new event wins over a clear.
    evt_set = RST_EVT;
    evt_set[EVT_EP0 +: EP_COUNT] = s.flags & ~s.flags_q;
    evt_set[EVT_SOF_OK]  = sof_i.valid & sof_i.crc_ok;
    evt_set[EVT_SOF_ERR] = sof_i.valid & ~sof_i.crc_ok;
    next_s.sticky = (s.sticky & ~evt_clr) | evt_set;

    next_s.irq = (|(next_s.flags & next_s.en)) | (|(next_s.sticky & next_s.mask));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s.dat     <= 32'h0000_0000;
      s.ack     <= 1'b0;
      s.irq     <= 1'b0;
      s.flags   <= RST_FLAGS;
      s.flags_q <= RST_FLAGS;
      s.en      <= RST_ENABLE;
      s.sticky  <= RST_EVT;
      s.mask    <= RST_EVT;
      s.frame   <= RST_FRAME;
      s.count   <= '0;
      s.cpu_ptr <= '0;
      s.eng_ptr <= '0;
      s.tx_data <= 8'h00;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      fifo_mem[mem_ep][mem_ptr] <= mem_wdat;
    end
  end

  assign wb_dat_o  = s.dat;
  assign wb_ack_o  = s.ack;
  assign irq_o     = s.irq;
  assign tx_data_o = s.tx_data;

  // Helper values sampled by the checks below.
  logic [7:0]            past_frame_lo;
  logic [FIFO_PTR_W-1:0] past_ptr;
  logic [EP_SEL_W-1:0]   past_ep;
  logic [7:0]            past_byte;

  always_ff @(posedge clk_i) begin
    past_frame_lo <= sof_i.frame[7:0];
    past_ptr      <= cur_ptr;
    past_ep       <= endpoint_index_i;
    past_byte     <= rd_byte;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_dp_access;
    dp_acc && !fifo_reset_i[endpoint_index_i] ##1 wb_ack_o;
  endsequence

  sequence s_dp_read;
    dp_acc && !wb_we_i ##1 wb_ack_o;
  endsequence

  property p_flag_set;
    (|ep_src_i[0]) |=> s.flags[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag 0 not set by source");

  property p_flag_clear;
    (ep_src_i[1] == 5'h00) |=> !s.flags[1];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag 1 not cleared");

  property p_irq_gate;
    irq_o == ((|(s.flags & s.en)) | (|(s.sticky & s.mask)));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated by enables");

  property p_count_bit7;
    cnt_rd |=> wb_ack_o && (wb_dat_o[31:7] == 25'h0);
  endproperty
  a_count_bit7: assert property (p_count_bit7) else $error("byte count bit 7 not zero");

  property p_frame_take;
    sof_i.valid && sof_i.crc_ok |=> s.frame[7:0] == past_frame_lo;
  endproperty
  a_frame_take: assert property (p_frame_take) else $error("frame number not taken");

  property p_frame_hold;
    sof_i.valid && !sof_i.crc_ok |=> $stable(s.frame);
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("bad frame changed number");

  property p_ptr_adv;
    s_dp_access |-> s.cpu_ptr[past_ep] == ptr_inc(past_ptr);
  endproperty
  a_ptr_adv: assert property (p_ptr_adv) else $error("pointer did not advance");

  property p_dp_read;
    s_dp_read |-> wb_dat_o[7:0] == past_byte;
  endproperty
  a_dp_read: assert property (p_dp_read) else $error("data port read wrong byte");

  property p_rx_count;
    rx_valid_i && !pkt_start_i && pkt_ep_i == 2'h0 && s.count[0] != COUNT_MAX
      |=> s.count[0] == $past(s.count[0]) + 7'h01;
  endproperty
  a_rx_count: assert property (p_rx_count) else $error("byte count not advanced");

  property p_reset_vals;
    $past(rst_i) |-> s.flags == RST_FLAGS && s.frame == RST_FRAME && s.count == '0;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

  property p_ack_answer;
    req && !rx_valid_i |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

  property p_count_clear;
    pkt_start_i && pkt_ep_i == 2'h2 |=> s.count[2] == RST_COUNT;
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("byte count not restarted");

  property p_count_sat;
    rx_valid_i && !pkt_start_i && pkt_ep_i == 2'h2 && s.count[2] == COUNT_MAX
      |=> s.count[2] == COUNT_MAX;
  endproperty
  a_count_sat: assert property (p_count_sat) else $error("byte count passed its limit");

  property p_sof_ok_evt;
    sof_i.valid && sof_i.crc_ok |=> s.sticky[EVT_SOF_OK];
  endproperty
  a_sof_ok_evt: assert property (p_sof_ok_evt) else $error("good frame event lost");

  property p_sof_err_evt;
    sof_i.valid && !sof_i.crc_ok |=> s.sticky[EVT_SOF_ERR];
  endproperty
  a_sof_err_evt: assert property (p_sof_err_evt) else $error("bad frame event lost");

  property p_flag_event;
    $rose(s.flags[2]) |=> s.sticky[EVT_EP0 + 2];
  endproperty
  a_flag_event: assert property (p_flag_event) else $error("flag 2 event lost");

endmodule // uef_endpoint_fifo

// ### uef_host_model.sv
// Packet engine stand-in that replays host-side USB traffic.
`timescale 1ns/1ns
module uef_host_model
  import uef_pkg::*;
(
  // Clock.
  input  wire logic                clk_i,
  // Engine side.
  output uef_src_t [EP_COUNT-1:0]  ep_src_o,
  output logic                     pkt_start_o,
  output logic     [EP_SEL_W-1:0]  pkt_ep_o,
  output logic                     rx_valid_o,
  output logic     [7:0]           rx_data_o,
  output logic                     tx_rd_o,
  input  wire logic [7:0]          tx_data_i,
  output uef_sof_t                 sof_o
);
  initial begin
    ep_src_o = '0;
    pkt_start_o = 1'b0;
    pkt_ep_o = '0;
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    tx_rd_o = 1'b0;
    sof_o = '0;
  end
  task automatic src(input logic [EP_SEL_W-1:0] ep, input logic [4:0] v);
    @(posedge clk_i);
    ep_src_o[ep] <= v;
  endtask
  task automatic start(input logic [EP_SEL_W-1:0] ep);
    @(posedge clk_i);
    pkt_ep_o <= ep;
    pkt_start_o <= 1'b1;
    @(posedge clk_i);
    pkt_start_o <= 1'b0;
  endtask
  // Released data line shows the inverse.
  task automatic rx(input logic [7:0] d);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_data_o <= d;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~d;
  endtask
  task automatic tx(output logic [7:0] d);
    @(posedge clk_i);
    tx_rd_o <= 1'b1;
    @(posedge clk_i);
    tx_rd_o <= 1'b0;
    @(negedge clk_i);
    d = tx_data_i;
  endtask
  task automatic sof(input logic [10:0] f, input logic ok);
    @(posedge clk_i);
    sof_o <= {1'b1, ok, f};
    @(posedge clk_i);
    sof_o <= {1'b0, ok, ~f};
  endtask
endmodule // uef_host_model

// ### uef_endpoint_fifo_test.sv
// Self-checking bench of the endpoint flag and FIFO access block.
`timescale 1ns/1ns
module uef_endpoint_fifo_test
  import uef_pkg::*;
;
  logic                   clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic     [9:0]         wb_adr_i;
  logic     [3:0]         wb_sel_i;
  logic     [31:0]        wb_dat_i, wb_dat_o, r;
  logic                   wb_ack_o, irq_o, pkt_start, rx_valid, tx_rd;
  logic     [1:0]         endpoint_index_i, pkt_ep;
  logic     [2:0]         fifo_reset_i;
  uef_src_t [2:0]         ep_src;
  uef_sof_t               sof;
  logic     [7:0]         rx_data, tx_data, d;
  logic     [7:0]         q [16];
  logic     [10:0]        f;
  int                     fails, comparisons, seed, e, s, k, j, n;
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  uef_endpoint_fifo i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .endpoint_index_i(endpoint_index_i), .fifo_reset_i(fifo_reset_i),
    .ep_src_i(ep_src), .pkt_start_i(pkt_start), .pkt_ep_i(pkt_ep),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .tx_rd_i(tx_rd),
    .tx_data_o(tx_data), .sof_i(sof)
  );
  uef_host_model i_host (
    .clk_i(clk_i), .ep_src_o(ep_src), .pkt_start_o(pkt_start), .pkt_ep_o(pkt_ep),
    .rx_valid_o(rx_valid), .rx_data_o(rx_data), .tx_rd_o(tx_rd), .tx_data_i(tx_data),
    .sof_o(sof)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] idx, input logic [31:0] wd);
    int t;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h1;
    wb_dat_i <= wd;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    if (wb_ack_o !== 1'b1) begin
      fails++;
      results();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    wb(1'b1, idx, {24'h0, v});
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] v);
    wb(1'b0, idx, 32'h0);
    chk(r, {24'h0, v});
  endtask
  task automatic irq(input logic v);
    repeat (3) @(negedge clk_i);
    chk({31'h0, irq_o}, {31'h0, v});
  endtask
  task automatic flush(input int ep);
    @(posedge clk_i);
    endpoint_index_i <= 2'(ep);
    fifo_reset_i <= 3'(1 << ep);
    @(posedge clk_i);
    fifo_reset_i <= 3'h0;
  endtask
  initial begin
    seed = 67;
    fails = 0;
    comparisons = 0;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = '0;
    wb_sel_i = 4'h0;
    wb_dat_i = '0;
    endpoint_index_i = 2'h0;
    fifo_reset_i = 3'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(IDX_EP_INT_FLAGS, 8'h00);
    rdc(IDX_EP_RX_BYTE_COUNT, 8'h00);
    rdc(IDX_FRAME_NUMBER_LOW, 8'h00);
    rdc(8'h01, 8'h00);
    $display("Test reset done");
    for (e = 0; e < 3; e++) begin
      for (s = 0; s < 5; s++) begin
        i_host.src(2'(e), 5'(1 << s));
        irq(1'b0);
        rdc(IDX_EP_INT_FLAGS, 8'(1 << e));
        wr(IDX_EP_IRQ_ENABLE, 8'(1 << e));
        rdc(IDX_EP_IRQ_ENABLE, 8'(1 << e));
        irq(1'b1);
        wr(IDX_EP_IRQ_ENABLE, 8'h00);
        irq(1'b0);
        i_host.src(2'(e), 5'h00);
        repeat (3) @(negedge clk_i);
        rdc(IDX_EP_INT_FLAGS, 8'h00);
      end
    end
    $display("Test flags done");
    for (k = 0; k < 4; k++) begin
      f = 11'($random(seed));
      i_host.sof(f, 1'b1);
      rdc(IDX_FRAME_NUMBER_LOW, f[7:0]);
      i_host.sof(~f, 1'b0);
      rdc(IDX_FRAME_NUMBER_LOW, f[7:0]);
    end
    $display("Test frame done");
    rdc(IDX_EVENT_STATUS, 8'h1F);
    wr(IDX_EVENT_MASK, 8'h08);
    irq(1'b1);
    wr(IDX_EVENT_MASK, 8'h00);
    irq(1'b0);
    wr(IDX_EVENT_MASK, 8'h08);
    wr(IDX_EVENT_STATUS, 8'h08);
    irq(1'b0);
    rdc(IDX_EVENT_STATUS, 8'h17);
    i_host.sof(f, 1'b1);
    irq(1'b1);
    wr(IDX_EVENT_MASK, 8'h00);
    $display("Test interrupts done");
    for (k = 0; k < 6; k++) begin
      e = k % 3;
      n = (k == 0) ? 0 : (k == 5) ? 130 : 1 + ($unsigned($random(seed)) % 12);
      for (j = 0; j < 16; j++) q[j] = 8'($random(seed));
      flush(e);
      i_host.start(2'(e));
      for (j = 0; j < n; j++) i_host.rx(q[j % 16]);
      rdc(IDX_EP_RX_BYTE_COUNT, 8'(n > 127 ? 127 : n));
      for (j = 0; j < n && j < 16; j++) rdc(IDX_EP_FIFO_DATA_PORT, q[j]);
      flush(e);
      for (j = 0; j < n && j < 16; j++) wr(IDX_EP_FIFO_DATA_PORT, ~q[j]);
      for (j = 0; j < n && j < 16; j++) begin
        i_host.tx(d);
        chk({24'h0, d}, {24'h0, ~q[j]});
      end
    end
    $display("Test data port done");
    @(posedge clk_i);
    endpoint_index_i <= 2'h3;
    rdc(IDX_EP_FIFO_DATA_PORT, 8'h00);
    rdc(IDX_EP_RX_BYTE_COUNT, 8'h00);
    @(posedge clk_i);
    rst_i <= 1'b1;
    endpoint_index_i <= 2'h2;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(IDX_FRAME_NUMBER_LOW, 8'h00);
    rdc(IDX_EP_RX_BYTE_COUNT, 8'h00);
    rdc(IDX_EP_INT_FLAGS, 8'h00);
    $display("Test corner cases done");
    results();
  end
endmodule // uef_endpoint_fifo_test
